// File: adc_cfg_pkg.sv
// constants for the converter clock and mode configuration block
package adc_cfg_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] CFG_OFFSET = 8'h12;
	localparam logic [7:0] STATUS_OFFSET = 8'h13;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam int LOW_POWER_BIT = 7;
	localparam int DIV_MSB = 6;
	localparam int DIV_LSB = 5;
	localparam int LONG_SAMPLE_BIT = 4;
	localparam int RES_MSB = 3;
	localparam int RES_LSB = 2;
	localparam int CLKSEL_MSB = 1;
	localparam int CLKSEL_LSB = 0;
	localparam int FULL_BIT = 0;
	localparam int FIFO_DEPTH_MAX = 8;
	localparam int CNT_W = 4;
	typedef enum logic [1:0] {
		SRC_BUS,
		SRC_BUS_HALF,
		SRC_ALT,
		SRC_ASYNC
	} clk_src_type;
	typedef enum logic [1:0] {
		RES_8BIT,
		RES_10BIT,
		RES_12BIT,
		RES_RESERVED
	} resolution_type;
endpackage

// File: conv_clk_divider.sv
// divides the selected source enable pulse by 1, 2, 4 or 8
`timescale 1ns/10ps
module conv_clk_divider
	import adc_cfg_pkg::*;
(
	input wire logic clk_i, // bus clock
	input wire logic srst_i, // synchronous reset, active high
	input wire logic src_en_i, // one pulse per source clock period
	input wire logic [1:0] div_sel_i, // divider field
	output logic conv_en_o // one pulse per conversion clock period
);
	logic [2:0] cnt_q;
	logic [2:0] limit;

	always_comb begin
		case (div_sel_i)
			2'b00: limit = 3'h0;
			2'b01: limit = 3'h1;
			2'b10: limit = 3'h3;
			default: limit = 3'h7;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cnt_q <= 3'h0;
			conv_en_o <= 1'b0;
		end else begin
			conv_en_o <= 1'b0;
			if (src_en_i) begin
				// a shrunk divider restarts rather than waiting for a wrap
				if (cnt_q >= limit) begin
					cnt_q <= 3'h0;
					conv_en_o <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 3'h1;
				end
			end
		end
	end
endmodule // conv_clk_divider

// File: adc_clock_mode_config.sv
// converter clock, resolution and sampling configuration with fifo full status
// Summary of operation
// [R1] full flag 1 when fifo full, else 0
// [R2] bit 7: 0 high speed, 1 low power
// [R3] divider field divides by 1, 2, 4, 8
// [R4] bit 4: 0 short, 1 long sample
// [R5] resolution 8, 10, 12 bits; 11 reserved
// [R6] source: bus, bus/2, alternate, asynchronous
// [R7] config register at 12h, resets to zero
// [R8] fifo mode forbids asynchronous clock source; the code only flags it on CLK_CONFLICT_O and still uses that source
`timescale 1ns/10ps
module adc_clock_mode_config
	import adc_cfg_pkg::*;
#(
	parameter int FIFO_DEPTH = FIFO_DEPTH_MAX
) (
	input wire logic CLK_I, // bus clock, 100 MHz
	input wire logic SRST_I, // synchronous reset, active high
	input wire logic [ADDR_W-1:0] ADDR_I, // register address
	input wire logic [7:0] WDATA_I, // write data
	input wire logic WR_I, // write strobe
	input wire logic RD_I, // read strobe
	output logic [7:0] RDATA_O, // read data, valid cycle after strobe
	input wire logic ALT_CLK_I, // alternate clock source pin
	input wire logic ASYNC_CLK_I, // asynchronous converter clock
	input wire logic RESULT_PUSH_I, // a conversion result enters the fifo
	input wire logic RESULT_POP_I, // software reads one result
	input wire logic [CNT_W-1:0] FIFO_LEVEL_I, // configured fifo depth, 0 = off
	output logic CONV_CLK_EN_O, // conversion clock enable pulse
	output logic LOW_POWER_O, // reduced power mode
	output logic LONG_SAMPLE_O, // long sample time
	output logic [1:0] RESOLUTION_O, // resolution select
	output logic [3:0] RESULT_BITS_O, // result width in bits
	output logic RESULT_FIFO_FULL_O, // result fifo full flag
	output logic CLK_CONFLICT_O // fifo on while async source chosen
);
	logic [7:0] cfg_q;
	logic [CNT_W-1:0] count_q;
	logic full_d;
	logic bus_half_q;
	logic [1:0] alt_sync_q;
	logic [1:0] async_sync_q;
	logic alt_prev_q;
	logic async_prev_q;
	logic src_en;
	logic conv_en;
	logic [CNT_W-1:0] depth;
	clk_src_type src;

	assign src = clk_src_type'(cfg_q[CLKSEL_MSB:CLKSEL_LSB]);

	// register write; every field is plain read/write
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			cfg_q <= CFG_RESET; // [R7]
		end else if (WR_I && ADDR_I == CFG_OFFSET) begin
			cfg_q <= WDATA_I; // [R7]
		end
	end

	// read port; unmapped addresses read zero
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			RDATA_O <= 8'h00;
		end else if (RD_I) begin
			case (ADDR_I)
				CFG_OFFSET: RDATA_O <= cfg_q; // [R7]
				STATUS_OFFSET: RDATA_O <= {7'h00, RESULT_FIFO_FULL_O}; // [R1]
				default: RDATA_O <= 8'h00;
			endcase
		end else begin
			RDATA_O <= 8'h00;
		end
	end

	// pin clocks pass two flops before any edge detection
	// the alternate pin is asynchronous to the bus clock; the first flop may go metastable
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			alt_sync_q <= 2'h0;
		end else begin
			alt_sync_q <= {alt_sync_q[0], ALT_CLK_I};
		end
	end

	// the asynchronous converter clock gets the same two flop treatment
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			async_sync_q <= 2'h0;
		end else begin
			async_sync_q <= {async_sync_q[0], ASYNC_CLK_I};
		end
	end

	// previous synchronised level of the alternate clock, only the second flop is read
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			alt_prev_q <= 1'b0;
		end else begin
			alt_prev_q <= alt_sync_q[1];
		end
	end

	// previous synchronised level of the asynchronous clock
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			async_prev_q <= 1'b0;
		end else begin
			async_prev_q <= async_sync_q[1];
		end
	end

	// half rate enable: bus clock halved without a second clock domain
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			bus_half_q <= 1'b0;
		end else begin
			bus_half_q <= ~bus_half_q;
		end
	end

	// source enable; pin clocks are limited to under a quarter of the bus rate
	always_comb begin
		case (src)
			SRC_BUS: src_en = 1'b1; // [R6]
			SRC_BUS_HALF: src_en = bus_half_q; // [R6]
			SRC_ALT: src_en = alt_sync_q[1] & ~alt_prev_q; // [R6]
			SRC_ASYNC: src_en = async_sync_q[1] & ~async_prev_q; // [R6]
			default: src_en = 1'b0;
		endcase
	end

	conv_clk_divider u_div (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.src_en_i(src_en),
		.div_sel_i(cfg_q[DIV_MSB:DIV_LSB]), // [R3]
		.conv_en_o(conv_en)
	);

	// mode outputs registered so every output leaves a flop
	// the enable pulse lags the divider by one cycle; the duty pattern is unchanged
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			CONV_CLK_EN_O <= 1'b0;
		end else begin
			CONV_CLK_EN_O <= conv_en; // [R3]
		end
	end

	// power mode: high speed when clear, reduced power when set
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			LOW_POWER_O <= 1'b0;
		end else begin
			LOW_POWER_O <= cfg_q[LOW_POWER_BIT]; // [R2]
		end
	end

	// sample time length for higher impedance sources
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			LONG_SAMPLE_O <= 1'b0;
		end else begin
			LONG_SAMPLE_O <= cfg_q[LONG_SAMPLE_BIT]; // [R4]
		end
	end

	// raw resolution code, kept beside the decoded width
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			RESOLUTION_O <= 2'h0;
		end else begin
			RESOLUTION_O <= cfg_q[RES_MSB:RES_LSB]; // [R5]
		end
	end

	// decoded result width; updates on the same edge as the raw code
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			RESULT_BITS_O <= 4'h8;
		end else begin
			case (resolution_type'(cfg_q[RES_MSB:RES_LSB]))
				RES_8BIT: RESULT_BITS_O <= 4'h8; // [R5]
				RES_10BIT: RESULT_BITS_O <= 4'ha; // [R5]
				RES_12BIT: RESULT_BITS_O <= 4'hc; // [R5]
				default: RESULT_BITS_O <= 4'h0; // reserved code converts nothing
			endcase
		end
	end

	// flags the setup that fifo mode forbids: fifo on with the asynchronous source chosen
	// indicator only: the chosen source is still honoured
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			CLK_CONFLICT_O <= 1'b0;
		end else begin
			CLK_CONFLICT_O <= (FIFO_LEVEL_I != '0) && (src == SRC_ASYNC); // [R8]
		end
	end

	// occupancy: depth code n gives n+1 entries, capped by the parameter
	always_comb begin
		if (FIFO_LEVEL_I == '0) begin
			depth = CNT_W'(1);
		end else if (FIFO_LEVEL_I >= CNT_W'(FIFO_DEPTH - 1)) begin
			depth = CNT_W'(FIFO_DEPTH);
		end else begin
			depth = FIFO_LEVEL_I + CNT_W'(1);
		end
	end

	// a push into a full fifo overwrites the oldest, count stays at depth
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			count_q <= '0;
		end else begin
			case ({RESULT_PUSH_I, RESULT_POP_I})
				2'b10: begin
					if (count_q < depth) begin
						count_q <= count_q + CNT_W'(1); // [R1]
					end
				end
				2'b01: begin
					if (count_q != '0) begin
						count_q <= count_q - CNT_W'(1);
					end
				end
				2'b11: begin
					if (count_q == '0) begin
						count_q <= CNT_W'(1);
					end
				end
				default: begin
					if (count_q > depth) begin
						count_q <= depth;
					end
				end
			endcase
		end
	end

	// full compares against the live depth so a shrunk depth reports full at once
	assign full_d = (count_q >= depth);

	// registered flag; no set/clear race since it follows the count each cycle
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			RESULT_FIFO_FULL_O <= 1'b0;
		end else begin
			RESULT_FIFO_FULL_O <= full_d; // [R1]
		end
	end
endmodule // adc_clock_mode_config

// File: adc_cfg_checker_properties.sv
// port assertions for the converter configuration block
`timescale 1ns/10ps
module adc_cfg_checker
	import adc_cfg_pkg::*;
(
	input wire logic CLK_I, // clock
	input wire logic SRST_I, // reset
	input wire logic [ADDR_W-1:0] ADDR_I, // address
	input wire logic [7:0] WDATA_I, // data
	input wire logic WR_I, // write
	input wire logic RD_I, // read
	input wire logic [7:0] RDATA_O, // read data
	input wire logic LOW_POWER_O, // power
	input wire logic LONG_SAMPLE_O, // sample
	input wire logic [1:0] RESOLUTION_O, // mode
	input wire logic [3:0] RESULT_BITS_O, // width
	input wire logic [CNT_W-1:0] FIFO_LEVEL_I, // fifo depth code
	input wire logic RESULT_PUSH_I, // result push
	input wire logic CONV_CLK_EN_O, // conversion enable
	input wire logic RESULT_FIFO_FULL_O, // full flag
	input wire logic CLK_CONFLICT_O // clock conflict
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SRST_I);
	wire logic wc = WR_I && ADDR_I == CFG_OFFSET;
	property p_md;
		logic [7:0] d;
		(wc, d = WDATA_I) |-> ##3 LOW_POWER_O == d[7] && LONG_SAMPLE_O == d[4]
			&& RESOLUTION_O == d[3:2];
	endproperty
	a_md: assert property (p_md) else $error("mode bits");
	// both outputs leave flops on the same edge, so they must agree every cycle
	property p_bt;
		RESULT_BITS_O == (&RESOLUTION_O ? 4'h0 : {1'b1, RESOLUTION_O, 1'b0});
	endproperty
	a_bt: assert property (p_bt) else $error("result width");
	property p_um;
		RD_I && ADDR_I != CFG_OFFSET && ADDR_I != STATUS_OFFSET |=> RDATA_O == 8'h00;
	endproperty
	a_um: assert property (p_um) else $error("unmapped read");
	property p_rs;
		@(posedge CLK_I) disable iff (1'b0) SRST_I |=> RDATA_O == 8'h00 && !LOW_POWER_O
			&& !LONG_SAMPLE_O && RESOLUTION_O == 2'h0 && RESULT_BITS_O == 4'h8
			&& !CONV_CLK_EN_O && !RESULT_FIFO_FULL_O && !CLK_CONFLICT_O;
	endproperty
	a_rs: assert property (p_rs) else $error("reset values");
	property p_fl;
		(FIFO_LEVEL_I == '0 && RESULT_PUSH_I) ##1 (FIFO_LEVEL_I == '0) |=> RESULT_FIFO_FULL_O;
	endproperty
	a_fl: assert property (p_fl) else $error("full flag");
	property p_cf;
		(wc && WDATA_I[1:0] == 2'b11) ##1 !wc ##1 (FIFO_LEVEL_I != '0) |=> CLK_CONFLICT_O;
	endproperty
	a_cf: assert property (p_cf) else $error("clock conflict");
endmodule // adc_cfg_checker
bind adc_clock_mode_config adc_cfg_checker chk (.*);

// File: tb_adc_clock_mode_config.sv
// self-checking bench for the converter configuration block
`timescale 1ns/10ps
module tb_adc_clock_mode_config
	import adc_cfg_pkg::*;
;
	logic clk = 0, srst = 1, wr = 0, rd = 0, rq = 0, alt = 0, asy = 0, push = 0, pop = 0;
	logic conv, full, cflt;
	logic [7:0] a = 0, wd = 0, rdat, d;
	logic [3:0] lvl = 0;
	logic [7:0] q[$];
	int n_errors = 0, checked = 0, n;
	always #5 clk = ~clk;
	// pin clocks stay below a quarter of the bus clock for the edge detectors
	always #40 alt = ~alt;
	always #80 asy = ~asy;
	adc_clock_mode_config dut (.CLK_I(clk), .SRST_I(srst), .ADDR_I(a), .WDATA_I(wd), .WR_I(wr),
		.RD_I(rd), .RDATA_O(rdat), .ALT_CLK_I(alt), .ASYNC_CLK_I(asy), .RESULT_PUSH_I(push),
		.RESULT_POP_I(pop), .FIFO_LEVEL_I(lvl), .CONV_CLK_EN_O(conv), .LOW_POWER_O(),
		.LONG_SAMPLE_O(), .RESOLUTION_O(), .RESULT_BITS_O(), .RESULT_FIFO_FULL_O(full),
		.CLK_CONFLICT_O(cflt));
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] v);
		checked++;
		if (v !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", s, e, v);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] v);
		wr <= w;
		rd <= !w;
		a <= ad;
		wd <= v;
		if (!w) q.push_back(v);
		@(posedge clk);
	endtask
	task automatic fifo(input logic p, input logic o, input logic e);
		push <= p;
		pop <= o;
		@(posedge clk);
		push <= 0;
		pop <= 0;
		repeat (2) @(posedge clk);
		chk("full", {7'h0, e}, {7'h0, full});
	endtask
	task automatic end_of_test;
		if (n_errors == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk) begin
		if (rq) chk("rdata", q.pop_front(), rdat);
		rq <= rd;
	end
	initial begin
		void'($urandom(32'hdab3a359));
		repeat (12) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		bus(0, CFG_OFFSET, CFG_RESET);
		for (int i = 0; i < 8; i++) begin
			d = $urandom;
			d[3:2] = i[1:0];
			bus(1, CFG_OFFSET, d);
			bus(1, 8'h11, ~d);
			bus(0, CFG_OFFSET, d);
			bus(0, {1'b1, d[6:0]}, 8'h00);
		end
		for (int k = 0; k < 16; k++) begin
			bus(1, CFG_OFFSET, {1'b0, k[1:0], 3'h0, k[3:2]});
			wr <= 0;
			repeat (300) @(posedge clk);
			n = 0;
			repeat (128) begin
				@(posedge clk);
				n += conv;
			end
			chk("pulses", 8'(128 >> (k % 4 + k / 4 + (k > 7))), n[7:0]);
		end
		lvl <= 4'h3;
		for (int i = 1; i <= 5; i++) fifo(1, 0, i >= 4);
		repeat (4) fifo(0, 1, 0);
		lvl <= 4'h0;
		fifo(1, 0, 1);
		fifo(1, 1, 1);
		fifo(0, 1, 0);
		lvl <= 4'h3;
		bus(1, CFG_OFFSET, 8'h03);
		wr <= 0;
		repeat (4) @(posedge clk);
		chk("conflict", 8'h01, {7'h0, cflt});
		lvl <= 4'h0;
		repeat (3) @(posedge clk);
		chk("conflict", 8'h00, {7'h0, cflt});
		end_of_test;
	end
endmodule // tb_adc_clock_mode_config
